// ==== design/ext_regulator_cfg.svh ====
`ifndef EXT_REGULATOR_CFG_SVH
`define EXT_REGULATOR_CFG_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OFS_HW_CTRL      12'h000
`define OFS_MODE_SUPPLY  12'h004
`define OFS_SUP_STAT_0   12'h008
`define OFS_SUP_STAT_1   12'h00C
`define OFS_MODE_STAT    12'h010

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define VSEL_LSB         0
`define VSEL_MSB         1
`define EN_BIT           0
`define UV_BIT           0
`define OC_BIT           0
`define LOCK_BIT         1
`define ON_BIT           2
`define OT_BIT           3
`define MODE_LSB         0
`define MODE_MSB         2

// ----------------------------------------------------------------
// Voltage codes and reset values
// ----------------------------------------------------------------
`define VSEL_5V0         2'h0
`define VSEL_3V3         2'h1
`define VSEL_1V8         2'h2
`define VSEL_1V2         2'h3
`define VSEL_RESET       `VSEL_3V3

// ----------------------------------------------------------------
// System operating mode codes
// ----------------------------------------------------------------
`define MODE_INIT        3'h0
`define MODE_NORMAL      3'h1
`define MODE_STOP        3'h2
`define MODE_SLEEP       3'h3
`define MODE_RESTART     3'h4
`define MODE_FAILSAFE    3'h5

`define WORD_ZERO        32'h0000_0000

`endif

// ==== design/ext_regulator_control.sv ====
`timescale 1ns/1ps
`include "ext_regulator_cfg.svh"

// Notes on behaviour
// - Voltage level comes from hardware control register
// - Enable bit turns regulator on in normal
// - Off in init/fail-safe, frozen in low-power modes
// - Four levels, 3.3 V after reset
// - First enable locks voltage selection writes
// - Lock released only by power loss
// - Enable bit stays writable after lock
// - Overcurrent trip sets sticky flag only
// - Overcurrent clear works only when condition gone
// - Undervoltage while regulator is on sets status-0 flag
// - Status-1 register reports regulator conditions
// - Base driver temperature feeds overtemperature protection

module ext_regulator_control
    import ext_regulator_pkg::*;
(
    input  wire logic      pclk,             // APB clock, 250 MHz
    input  wire logic      presetn,          // Power-on reset, active low
    input  wire logic      psel,             // APB select
    input  wire logic      penable,          // APB access phase
    input  wire logic      pwrite,           // APB write direction
    input  wire addr_t     paddr,            // APB byte address
    input  wire word_t     pwdata,           // APB write data
    output word_t          prdata,           // APB read data
    output logic           pready,           // APB ready
    output logic           pslverr,          // APB error, unmapped address
    input  wire sys_mode_t sys_mode,         // System operating mode
    input  wire logic      oc_comparator,    // Shunt overcurrent comparator
    input  wire logic      uv_comparator,    // Output undervoltage comparator
    input  wire logic      temp_sensor_hot,  // Base driver temperature sensor
    output logic           aux_regulator,    // Regulator drive enable
    output vsel_t          aux_voltage_select, // Output voltage code
    output logic           aux_overtemp_alarm  // To overtemperature protection
);

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------

    // Exact full-address match against one register offset
    function automatic logic reg_hit(input addr_t addr, input addr_t ofs);
        reg_hit = (addr == ofs);
    endfunction : reg_hit

    // Write-one-to-clear request for one status bit; a zero in that
    // position leaves the flag alone, so flags can be cleared singly
    function automatic logic w1c_hit(input logic strobe, input word_t data, input int unsigned bit_pos);
        w1c_hit = strobe & data[bit_pos];
    endfunction : w1c_hit

    logic hit_hw_ctrl;
    logic hit_mode_supply;
    logic hit_stat_0;
    logic hit_stat_1;
    logic hit_mode_stat;
    logic hit_any;

    assign hit_hw_ctrl     = reg_hit(paddr, `OFS_HW_CTRL);
    assign hit_mode_supply = reg_hit(paddr, `OFS_MODE_SUPPLY);
    assign hit_stat_0      = reg_hit(paddr, `OFS_SUP_STAT_0);
    assign hit_stat_1      = reg_hit(paddr, `OFS_SUP_STAT_1);
    assign hit_mode_stat   = reg_hit(paddr, `OFS_MODE_STAT);
    assign hit_any         = hit_hw_ctrl | hit_mode_supply | hit_stat_0 |
                             hit_stat_1 | hit_mode_stat;

    // ------------------------------------------------------------
    // APB handshake
    // ------------------------------------------------------------

    // One wait state: pready rises in the second access cycle,
    // which keeps prdata a plain register output
    // Setup cycle, access cycle with pready low, access cycle with
    // pready high; a write lands on the edge ending the last one.
    // A master that holds penable past that edge is served again two
    // cycles later, since pready_next needs pready low first
    logic access;
    logic complete;
    logic wr_strobe;
    logic pready_next;

    assign access      = psel & penable;
    assign complete    = access & pready;
    assign wr_strobe   = complete & pwrite & hit_any;
    assign pready_next = access & ~pready;

    // Ready and error registers; the error rides with ready so a
    // master never sees it outside the completing cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= pready_next;
            pslverr <= pready_next & ~hit_any;
        end
    end

    // ------------------------------------------------------------
    // Write strobes per register
    // ------------------------------------------------------------
    logic wr_hw_ctrl;
    logic wr_mode_supply;
    logic wr_stat_0;
    logic wr_stat_1;

    assign wr_hw_ctrl     = wr_strobe & hit_hw_ctrl;
    assign wr_mode_supply = wr_strobe & hit_mode_supply;
    assign wr_stat_0      = wr_strobe & hit_stat_0;
    assign wr_stat_1      = wr_strobe & hit_stat_1;

    // ------------------------------------------------------------
    // Voltage selection and configuration lock
    // ------------------------------------------------------------
    vsel_t vsel_reg;
    vsel_t vsel_next;
    logic  lock_reg;
    logic  lock_next;
    logic  enable_reg;
    logic  enable_next;
    logic  new_enable;

    logic  cfg_write_ok;
    logic  lock_set;

    assign new_enable = pwdata[`EN_BIT];

    // A configuration write counts only while the lock is open
    assign cfg_write_ok = wr_hw_ctrl & ~lock_reg;

    // The first write that sets the enable bit closes the lock in any
    // mode, so software cannot dodge it by enabling outside normal
    assign lock_set = wr_mode_supply & new_enable;

    // Selection is frozen once locked; lock_reg takes effect from the cycle after
    // the write that sets the enable bit, which never shares a cycle with a config write
    assign vsel_next = cfg_write_ok ? pwdata[`VSEL_MSB:`VSEL_LSB] :
                       vsel_reg;

    // Lock never clears while powered; only presetn reopens it
    assign lock_next = lock_reg | lock_set;

    // Enable bit is writable regardless of the lock
    assign enable_next = wr_mode_supply ? new_enable : enable_reg;

    // Configuration registers; presetn stands for supply loss
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vsel_reg   <= `VSEL_RESET;
            lock_reg   <= 1'b0;
            enable_reg <= 1'b0;
        end else begin
            vsel_reg   <= vsel_next;
            lock_reg   <= lock_next;
            enable_reg <= enable_next;
        end
    end

    // ------------------------------------------------------------
    // Mode gating of the regulator
    // ------------------------------------------------------------
    logic reg_on;

    // Regulator state follows the operating mode
    mode_gate u_mode_gate (
        .pclk      (pclk),
        .presetn   (presetn),
        .sys_mode  (sys_mode),
        .sw_enable (enable_reg),
        .reg_on    (reg_on)
    );

    // ------------------------------------------------------------
    // Status flags
    // ------------------------------------------------------------
    logic oc_flag;
    logic uv_flag;
    logic ot_flag;
    logic uv_event;

    // Undervoltage counts only while the regulator is driven
    assign uv_event = uv_comparator & reg_on;

    // ------------------------------------------------------------
    // Software clear requests
    // ------------------------------------------------------------
    logic oc_clear_req;
    logic uv_clear_req;
    logic ot_clear_req;
    logic oc_clear_allow;
    logic ot_clear_allow;

    // One decode per flag; a status write may clear several at once
    assign oc_clear_req = w1c_hit(wr_stat_1, pwdata, `OC_BIT);
    assign uv_clear_req = w1c_hit(wr_stat_0, pwdata, `UV_BIT);
    assign ot_clear_req = w1c_hit(wr_stat_1, pwdata, `OT_BIT);

    // A clear while the condition persists would lose the report,
    // so it is refused until the comparator or sensor has dropped
    assign oc_clear_allow = ~oc_comparator;
    assign ot_clear_allow = ~temp_sensor_hot;

    // Overcurrent: flag only, current limiting stays analogue
    sticky_flag u_oc_flag (
        .pclk        (pclk),
        .presetn     (presetn),
        .set_event   (oc_comparator),
        .clear_req   (oc_clear_req),
        .clear_allow (oc_clear_allow),
        .flag        (oc_flag)
    );

    // Undervoltage flag in status register 0
    sticky_flag u_uv_flag (
        .pclk        (pclk),
        .presetn     (presetn),
        .set_event   (uv_event),
        .clear_req   (uv_clear_req),
        .clear_allow (1'b1),
        .flag        (uv_flag)
    );

    // Overtemperature flag; a clear is refused while still hot
    sticky_flag u_ot_flag (
        .pclk        (pclk),
        .presetn     (presetn),
        .set_event   (temp_sensor_hot),
        .clear_req   (ot_clear_req),
        .clear_allow (ot_clear_allow),
        .flag        (ot_flag)
    );

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    word_t rd_hw_ctrl;
    word_t rd_mode_supply;
    word_t rd_stat_0;
    word_t rd_stat_1;
    word_t rd_mode_stat;
    word_t rd_mux;
    word_t prdata_next;

    // Field placement per register; unused bits read as zero
    always_comb begin
        rd_hw_ctrl     = `WORD_ZERO;
        rd_mode_supply = `WORD_ZERO;
        rd_stat_0      = `WORD_ZERO;
        rd_stat_1      = `WORD_ZERO;
        rd_mode_stat   = `WORD_ZERO;
        rd_hw_ctrl[`VSEL_MSB:`VSEL_LSB]   = vsel_reg;
        rd_mode_supply[`EN_BIT]           = enable_reg;
        rd_stat_0[`UV_BIT]                = uv_flag;
        rd_stat_1[`OC_BIT]                = oc_flag;
        rd_stat_1[`LOCK_BIT]              = lock_reg;
        rd_stat_1[`ON_BIT]                = reg_on;
        rd_stat_1[`OT_BIT]                = ot_flag;
        rd_mode_stat[`MODE_MSB:`MODE_LSB] = sys_mode;
    end

    // Read select
    assign rd_mux = ({32{hit_hw_ctrl}}     & rd_hw_ctrl)     |
                    ({32{hit_mode_supply}} & rd_mode_supply) |
                    ({32{hit_stat_0}}      & rd_stat_0)      |
                    ({32{hit_stat_1}}      & rd_stat_1)      |
                    ({32{hit_mode_stat}}   & rd_mode_stat);

    logic rd_capture;

    // Data captured in the cycle pready rises, zero otherwise, so a
    // stale word never lingers on the bus between transfers
    assign rd_capture  = pready_next & ~pwrite;
    assign prdata_next = rd_capture ? rd_mux : `WORD_ZERO;

    // Read data register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= `WORD_ZERO;
        end else begin
            prdata <= prdata_next;
        end
    end

    // ------------------------------------------------------------
    // Outputs to the analogue side
    // ------------------------------------------------------------

    // Registered again so every top output comes from a flop;
    // costs one cycle of latency, harmless against analogue rates.
    // The alarm follows the raw sensor, not the sticky flag, so the
    // protection logic releases as soon as the driver has cooled
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            aux_regulator      <= 1'b0;
            aux_voltage_select <= `VSEL_RESET;
            aux_overtemp_alarm <= 1'b0;
        end else begin
            aux_regulator      <= reg_on;
            aux_voltage_select <= vsel_reg;
            aux_overtemp_alarm <= temp_sensor_hot;
        end
    end

endmodule : ext_regulator_control

// ==== design/ext_regulator_pkg.sv ====
package ext_regulator_pkg;
    typedef logic [1:0]  vsel_t;
    typedef logic [2:0]  sys_mode_t;
    typedef logic [31:0] word_t;
    typedef logic [11:0] addr_t;
endpackage : ext_regulator_pkg

// ==== design/mode_gate.sv ====
`timescale 1ns/1ps
`include "ext_regulator_cfg.svh"

// ----------------------------------------------------------------
// Regulator on/off by system operating mode
// ----------------------------------------------------------------
module mode_gate
    import ext_regulator_pkg::*;
(
    input  wire logic      pclk,       // System clock
    input  wire logic      presetn,    // Async reset, active low
    input  wire sys_mode_t sys_mode,   // Current system operating mode
    input  wire logic      sw_enable,  // Software enable bit
    output logic           reg_on      // Regulator drive request
);

    logic on_next;
    logic mode_off;
    logic mode_sw;

    // Mode decode; unknown codes are treated as off for safety
    assign mode_sw  = (sys_mode == `MODE_NORMAL);
    assign mode_off = (sys_mode == `MODE_INIT) || (sys_mode == `MODE_FAILSAFE) ||
                      ((sys_mode != `MODE_STOP) && (sys_mode != `MODE_SLEEP) &&
                       (sys_mode != `MODE_RESTART) && !mode_sw);

    // Low-power and restart modes freeze the last state
    assign on_next = mode_off ? 1'b0 :
                     mode_sw  ? sw_enable :
                     reg_on;

    // Drive request register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reg_on <= 1'b0;
        end else begin
            reg_on <= on_next;
        end
    end

endmodule : mode_gate

// ==== design/sticky_flag.sv ====
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Sticky status flag, set wins over clear
// ----------------------------------------------------------------
module sticky_flag (
    input  wire logic pclk,         // System clock
    input  wire logic presetn,      // Async reset, active low
    input  wire logic set_event,    // Hardware event, level or pulse
    input  wire logic clear_req,    // Software clear, one cycle
    input  wire logic clear_allow,  // Clear permitted this cycle
    output logic      flag          // Sticky flag
);

    logic flag_next;

    // A clear that meets a new event is dropped so the event survives
    assign flag_next = set_event ? 1'b1 :
                       (clear_req && clear_allow) ? 1'b0 : flag;

    // Flag storage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag <= 1'b0;
        end else begin
            flag <= flag_next;
        end
    end

endmodule : sticky_flag

// ==== verif/apb_host.sv ====
`timescale 1ns/1ps
// ------------------------------
// Host side of the register bus
// ------------------------------
module apb_host
    import ext_regulator_pkg::*;
(
    input  wire logic  pclk,    // Clock
    output logic       psel,    // Select
    output logic       penable, // Access
    output logic       pwrite,  // Direction
    output addr_t      paddr,   // Address
    output word_t      pwdata,  // Write data
    input  wire word_t prdata,  // Read data
    input  wire logic  pready,  // Ready
    input  wire logic  pslverr  // Error
);
    // Idle bus from time zero
    initial begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = '0;
        pwdata  = '0;
    end

    // One transfer; an idle cycle first avoids double drives between calls
    task automatic xfer(input logic w, input addr_t a, input word_t d, output word_t rd, output logic err);
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Waits as long as the slave needs; only the bench watchdog ends a hang
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
endmodule : apb_host

// ==== verif/ext_regulator_control_properties.sv ====
`timescale 1ns/1ps
`include "ext_regulator_cfg.svh"
// ------------------------------
// Port-level checks
// ------------------------------
module ext_regulator_control_properties
    import ext_regulator_pkg::*;
(
    input wire logic      pclk,               // Clock
    input wire logic      presetn,            // Reset, active low
    input wire logic      psel,               // Select
    input wire logic      penable,            // Access
    input wire logic      pwrite,             // Direction
    input wire addr_t     paddr,              // Address
    input wire word_t     pwdata,             // Write data
    input wire word_t     prdata,             // Read data
    input wire logic      pready,             // Ready
    input wire logic      pslverr,            // Error
    input wire sys_mode_t sys_mode,           // Mode
    input wire logic      oc_comparator,      // Overcurrent
    input wire logic      uv_comparator,      // Undervoltage
    input wire logic      temp_sensor_hot,    // Hot
    input wire logic      aux_regulator,      // Drive
    input wire vsel_t     aux_voltage_select, // Voltage code
    input wire logic      aux_overtemp_alarm  // Alarm
);
    logic done;
    logic locked_reg;

    // Completed good write
    assign done = psel && penable && pready && pwrite && !pslverr;

    // Own copy of the lock; only reset may clear it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            locked_reg <= 1'b0;
        else if (done && paddr == `OFS_MODE_SUPPLY && pwdata[0])
            locked_reg <= 1'b1;
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_init_off: assert property ((sys_mode == `MODE_INIT)[*3] |-> !aux_regulator)
        else $error("regulator on in init mode");
    chk_failsafe_off: assert property ((sys_mode == `MODE_FAILSAFE)[*3] |-> !aux_regulator)
        else $error("regulator on in fail-safe mode");
    chk_freeze_hold: assert property (
        (sys_mode inside {`MODE_STOP, `MODE_SLEEP, `MODE_RESTART})[*3] |-> $stable(aux_regulator))
        else $error("regulator changed in a fixed mode");
    chk_enable_follow: assert property (
        (done && paddr == `OFS_MODE_SUPPLY && sys_mode == `MODE_NORMAL)
        ##1 (sys_mode == `MODE_NORMAL)[*3] |-> aux_regulator == $past(pwdata[0], 3))
        else $error("regulator does not follow enable");
    chk_vsel_write: assert property (
        done && paddr == `OFS_HW_CTRL && !locked_reg |-> ##2 aux_voltage_select == $past(pwdata[1:0], 2))
        else $error("voltage select not taken");
    chk_vsel_lock: assert property (locked_reg |=> $stable(aux_voltage_select))
        else $error("voltage select changed after lock");
    chk_ready_timing: assert property (psel && !penable ##1 psel && penable |-> !pready ##1 pready)
        else $error("ready not in second access cycle");
    chk_ready_pulse: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    chk_alarm_follow: assert property (temp_sensor_hot |=> aux_overtemp_alarm)
        else $error("alarm does not follow sensor");

    cover property (locked_reg && aux_regulator);
    cover property (pslverr);
    cover property (sys_mode == `MODE_STOP && aux_regulator);
endmodule : ext_regulator_control_properties

bind ext_regulator_control ext_regulator_control_properties ext_regulator_control_properties_i (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .sys_mode, .oc_comparator, .uv_comparator, .temp_sensor_hot, .aux_regulator,
    .aux_voltage_select, .aux_overtemp_alarm
);

// ==== verif/ext_regulator_control_test.sv ====
`timescale 1ns/1ps
`include "ext_regulator_cfg.svh"
// ------------------------------
// Bench top
// ------------------------------
module ext_regulator_control_test
    import ext_regulator_pkg::*;
;
    logic      pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic      oc_comparator, uv_comparator, temp_sensor_hot, aux_regulator, aux_overtemp_alarm;
    addr_t     paddr;
    word_t     pwdata, prdata, rd;
    sys_mode_t sys_mode;
    vsel_t     aux_voltage_select;
    int        fails, checked;

    ext_regulator_control ext_regulator_control_i (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .sys_mode, .oc_comparator, .uv_comparator, .temp_sensor_hot, .aux_regulator,
        .aux_voltage_select, .aux_overtemp_alarm
    );
    apb_host apb_host_i (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);

    // 250 MHz clock
    initial pclk = 1'b0;
    always #2 pclk = ~pclk;

    // ------------------------------
    // Helpers
    // ------------------------------
    task automatic cmp(input word_t got, input word_t exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp
    task automatic wr(input addr_t a, input word_t d);
        apb_host_i.xfer(1'b1, a, d, rd, err);
    endtask : wr
    task automatic rdc(input addr_t a, input word_t exp);
        apb_host_i.xfer(1'b0, a, '0, rd, err);
        cmp(rd, exp);
    endtask : rdc
    // Mode change, then time for the two-stage gate to settle
    task automatic set_mode(input sys_mode_t m);
        @(posedge pclk);
        sys_mode <= m;
        repeat (4) @(posedge pclk);
    endtask : set_mode
    task automatic stop_test;
        if (fails == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : stop_test

    // ------------------------------
    // Scenarios
    // ------------------------------
    task automatic t_reset;
        cmp(aux_voltage_select, `VSEL_RESET);
        rdc(`OFS_HW_CTRL, 32'h0000_0001);
        apb_host_i.xfer(1'b0, 12'h020, '0, rd, err);
        cmp({rd[30:0], err}, 32'h0000_0001);
    endtask : t_reset
    // All four codes while unlocked, ending on 1.8 V
    task automatic t_select;
        set_mode(`MODE_NORMAL);
        for (int i = 3; i < 7; i++) begin
            wr(`OFS_HW_CTRL, i & 3);
            rdc(`OFS_HW_CTRL, i & 3);
            cmp(aux_voltage_select, i & 3);
        end
    endtask : t_select
    task automatic t_gate;
        set_mode(`MODE_INIT);
        wr(`OFS_MODE_SUPPLY, 1);
        repeat (4) @(posedge pclk);
        cmp(aux_regulator, 0);
        rdc(`OFS_SUP_STAT_1, 32'h0000_0002);
        set_mode(`MODE_NORMAL);
        cmp(aux_regulator, 1);
        wr(`OFS_HW_CTRL, 0);
        rdc(`OFS_HW_CTRL, 2);
        cmp(aux_voltage_select, `VSEL_1V8);
        for (int m = 2; m < 5; m++) begin
            set_mode(m);
            wr(`OFS_MODE_SUPPLY, 0);
            repeat (4) @(posedge pclk);
            cmp(aux_regulator, 1);
            set_mode(`MODE_NORMAL);
            cmp(aux_regulator, 0);
            wr(`OFS_MODE_SUPPLY, 1);
            repeat (4) @(posedge pclk);
            cmp(aux_regulator, 1);
        end
        set_mode(`MODE_FAILSAFE);
        cmp(aux_regulator, 0);
        set_mode(`MODE_NORMAL);
    endtask : t_gate
    task automatic t_flags;
        oc_comparator <= 1'b1;
        rdc(`OFS_SUP_STAT_1, 32'h0000_0007);
        cmp(aux_regulator, 1);
        wr(`OFS_SUP_STAT_1, 1);
        rdc(`OFS_SUP_STAT_1, 32'h0000_0007);
        oc_comparator <= 1'b0;
        wr(`OFS_SUP_STAT_1, 1);
        rdc(`OFS_SUP_STAT_1, 32'h0000_0006);
        for (int k = 0; k < 2; k++) begin
            @(posedge pclk);
            uv_comparator <= 1'b1;
            @(posedge pclk);
            uv_comparator <= 1'b0;
            rdc(`OFS_SUP_STAT_0, k ? 0 : 1);
            wr(`OFS_SUP_STAT_0, 1);
            set_mode(`MODE_FAILSAFE);
        end
        temp_sensor_hot <= 1'b1;
        repeat (2) @(posedge pclk);
        cmp(aux_overtemp_alarm, 1);
        rdc(`OFS_SUP_STAT_1, 32'h0000_000A);
        temp_sensor_hot <= 1'b0;
        wr(`OFS_SUP_STAT_1, 32'h0000_0008);
        rdc(`OFS_SUP_STAT_1, 32'h0000_0002);
    endtask : t_flags
    // Supply loss is the only way out of the lock
    task automatic t_power_loss;
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        cmp(aux_voltage_select, `VSEL_RESET);
        rdc(`OFS_SUP_STAT_1, 0);
        wr(`OFS_HW_CTRL, 0);
        rdc(`OFS_HW_CTRL, 0);
    endtask : t_power_loss

    // Main sequence
    initial begin
        presetn         = 1'b0;
        sys_mode        = `MODE_INIT;
        oc_comparator   = 1'b0;
        uv_comparator   = 1'b0;
        temp_sensor_hot = 1'b0;
        fails           = 0;
        checked         = 0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_select();
        t_gate();
        t_flags();
        t_power_loss();
        stop_test();
    end

    // Watchdog, about forty times the expected run
    initial begin
        #40000;
        fails++;
        stop_test();
    end
endmodule : ext_regulator_control_test
